// ---- orspi_pkg.sv ----
// Constants, types and helpers of the octal reduced/serial port interface
//
// Summary of operation
// - Device changes reduced receive bits with clock
// - Carrier sense/data valid follows receive data
// - Receive error held at least one clock
// - Serial receive bits driven with the clock
package orspi_pkg;

    localparam int NUM_PORTS = 8;
    localparam int NUM_GROUPS = 2;
    localparam int GROUP_PORTS = 4;
    localparam int SEG_BITS = 10;
    localparam int RX_WORD_W = 3;
    localparam int BUF_DEPTH = 2;

    // Clock rates in MHz
    localparam int REF_CLK_MHZ = 100;
    localparam int RMII_LINK_MHZ = 50;
    localparam int SMII_LINK_MHZ = 125;

    // Cycles between reset release and strap capture
    localparam logic [1:0] SETTLE_LAST = 2'h2;
    localparam logic [1:0] SETTLE_RESET = 2'h0;

    // Segment counter
    localparam logic [3:0] SEG_LAST = 4'h9;
    localparam logic [3:0] SEG_IDLE = 4'hf;
    localparam logic [3:0] SEG_FIRST = 4'h0;

    // Byte assembler
    localparam logic [2:0] ASM_FULL = 3'h4;
    localparam logic [2:0] ASM_RESET = 3'h0;

    // Serial segment field positions
    localparam int SEG_CRS_POS = 0;
    localparam int SEG_DV_POS = 1;
    localparam int SEG_DATA_POS = 2;
    localparam int TX_ER_POS = 0;
    localparam int TX_EN_POS = 1;

    // Word field positions in the receive buffer
    localparam int WORD_ERR_POS = 2;

    localparam logic [9:0] SEG_RESET = 10'h000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    typedef enum logic {
        ORSPI_MODE_REDUCED = 1'b0,
        ORSPI_MODE_SERIAL = 1'b1
    } orspi_mode_t;

    typedef enum logic [1:0] {
        ORSPI_ST_RESET = 2'b00,
        ORSPI_ST_SETTLE = 2'b01,
        ORSPI_ST_RUN = 2'b11
    } orspi_state_t;

    function automatic int orspi_group_of(input int port);
        orspi_group_of = port / GROUP_PORTS;
    endfunction

endpackage

// ---- orspi_buf2.sv ----
// Two-entry valid/ready buffer in the receive data path
`timescale 1ns/1ps
`default_nettype none
module orspi_buf2
    import orspi_pkg::*;
#(
    parameter int WIDTH = RX_WORD_W,
    parameter int DEPTH = BUF_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem_reg[rd_reg];

    always_comb begin
        push = in_valid & in_ready;
        pop = out_valid & out_ready;
        mem_next = mem_reg;
        wr_next = wr_reg;
        rd_next = rd_reg;
        cnt_next = cnt_reg;
        if (push) begin
            mem_next[wr_reg] = in_data;
            wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : AW'(wr_reg + 1'b1);
        end
        if (pop) begin
            rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : AW'(rd_reg + 1'b1);
        end
        if (push && !pop) begin
            cnt_next = (AW+1)'(cnt_reg + 1'b1);
        end else if (pop && !push) begin
            cnt_next = (AW+1)'(cnt_reg - 1'b1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            wr_reg <= wr_next;
            rd_reg <= rd_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire

// ---- orspi_top.sv ----
// Octal reduced/serial system-side port interface, device end
`timescale 1ns/1ps
`default_nettype none
module orspi_top
    import orspi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic shared_reference_clock,
    input wire logic serial_mode_strap,
    input wire logic [7:0] reduced_tx_bit0,
    input wire logic [7:0] reduced_tx_bit1,
    input wire logic [7:0] reduced_tx_enable,
    output logic [7:0] reduced_rx_bit0,
    output logic [7:0] reduced_rx_bit1,
    output logic [7:0] carrier_sense_data_valid,
    output logic [7:0] reduced_rx_error,
    output logic reduced_out_oe_n,
    input wire logic [7:0] serial_tx_in,
    output logic [7:0] serial_rx_out,
    output logic serial_rx_oe_n,
    input wire logic [1:0] serial_segment_sync,
    input wire logic [7:0] rx_word_valid,
    output logic [7:0] rx_word_ready,
    input wire logic [7:0][1:0] rx_dibit,
    input wire logic [7:0] rx_word_error,
    input wire logic [7:0] rx_carrier,
    output logic [7:0] tx_valid,
    output logic [7:0][7:0] tx_data,
    output logic [7:0] tx_error,
    output logic link_serial_mode,
    output logic link_running
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
    logic strap_s1_reg, strap_s2_reg;
    logic [7:0] txb0_s1_reg, txb0_s2_reg, txb1_s1_reg, txb1_s2_reg;
    logic [7:0] txen_s1_reg, txen_s2_reg, stx_s1_reg, stx_s2_reg;
    logic [1:0] sync_s1_reg, sync_s2_reg;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            clk_s3_reg <= 1'b0;
            strap_s1_reg <= 1'b0;
            strap_s2_reg <= 1'b0;
            txb0_s1_reg <= 8'h00;
            txb0_s2_reg <= 8'h00;
            txb1_s1_reg <= 8'h00;
            txb1_s2_reg <= 8'h00;
            txen_s1_reg <= 8'h00;
            txen_s2_reg <= 8'h00;
            stx_s1_reg <= 8'h00;
            stx_s2_reg <= 8'h00;
            sync_s1_reg <= 2'h0;
            sync_s2_reg <= 2'h0;
        end else begin
            clk_s1_reg <= shared_reference_clock;
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            strap_s1_reg <= serial_mode_strap;
            strap_s2_reg <= strap_s1_reg;
            txb0_s1_reg <= reduced_tx_bit0;
            txb0_s2_reg <= txb0_s1_reg;
            txb1_s1_reg <= reduced_tx_bit1;
            txb1_s2_reg <= txb1_s1_reg;
            txen_s1_reg <= reduced_tx_enable;
            txen_s2_reg <= txen_s1_reg;
            stx_s1_reg <= serial_tx_in;
            stx_s2_reg <= stx_s1_reg;
            sync_s1_reg <= serial_segment_sync;
            sync_s2_reg <= sync_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // Receive buffers
    // ------------------------------------------------------------
    logic [7:0] buf_valid, drain;
    logic [7:0][RX_WORD_W-1:0] buf_data;

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_buf
            orspi_buf2 u_buf (
                .ref_clk(ref_clk),
                .rst(rst),
                .in_valid(rx_word_valid[gp]),
                .in_ready(rx_word_ready[gp]),
                .in_data({rx_word_error[gp], rx_dibit[gp]}),
                .out_valid(buf_valid[gp]),
                .out_ready(drain[gp]),
                .out_data(buf_data[gp])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Mode, link and port state
    // ------------------------------------------------------------
    orspi_state_t st_reg, st_next;
    orspi_mode_t mode_reg, mode_next;
    logic [1:0] settle_reg, settle_next;
    logic [7:0] rxb0_reg, rxb0_next, rxb1_reg, rxb1_next;
    logic [7:0] csdv_reg, csdv_next, rxer_reg, rxer_next;
    logic [7:0] srx_reg, srx_next;
    logic red_oe_n_reg, red_oe_n_next, ser_oe_n_reg, ser_oe_n_next;
    logic [7:0] txv_reg, txv_next, txe_reg, txe_next;
    logic [7:0][7:0] txd_reg, txd_next;
    logic [1:0][3:0] seg_cnt_reg, seg_cnt_next;
    logic [7:0][9:0] rx_seg_reg, rx_seg_next, tx_sh_reg, tx_sh_next;
    logic [7:0][7:0] asm_reg, asm_next;
    logic [7:0][2:0] asm_cnt_reg, asm_cnt_next;
    logic link_edge;

    always_comb begin
        logic [9:0] word;
        int g;
        word = SEG_RESET;
        g = 0;
        link_edge = clk_s2_reg & ~clk_s3_reg;
        st_next = st_reg;
        mode_next = mode_reg;
        settle_next = settle_reg;
        rxb0_next = rxb0_reg;
        rxb1_next = rxb1_reg;
        csdv_next = csdv_reg;
        rxer_next = rxer_reg;
        srx_next = srx_reg;
        red_oe_n_next = red_oe_n_reg;
        ser_oe_n_next = ser_oe_n_reg;
        txv_next = 8'h00;
        txe_next = txe_reg;
        txd_next = txd_reg;
        seg_cnt_next = seg_cnt_reg;
        rx_seg_next = rx_seg_reg;
        tx_sh_next = tx_sh_reg;
        asm_next = asm_reg;
        asm_cnt_next = asm_cnt_reg;
        drain = 8'h00;

        case (st_reg)
            ORSPI_ST_RESET: begin
                st_next = ORSPI_ST_SETTLE;
            end
            ORSPI_ST_SETTLE: begin
                settle_next = 2'(settle_reg + 1'b1);
                if (settle_reg == SETTLE_LAST) begin
                    st_next = ORSPI_ST_RUN;
                    mode_next = orspi_mode_t'(strap_s2_reg);
                    red_oe_n_next = strap_s2_reg;
                    ser_oe_n_next = ~strap_s2_reg;
                end
            end
            ORSPI_ST_RUN: begin
                if (link_edge && mode_reg == ORSPI_MODE_REDUCED) begin
                    for (int p = 0; p < NUM_PORTS; p++) begin
                        csdv_next[p] = rx_carrier[p] | buf_valid[p];
                        // Outputs move only on a link clock edge
                        if (buf_valid[p]) begin
                            drain[p] = 1'b1;
                            rxb0_next[p] = buf_data[p][0];
                            rxb1_next[p] = buf_data[p][1];
                            // Held a full link period
                            rxer_next[p] = buf_data[p][WORD_ERR_POS];
                        end else begin
                            rxb0_next[p] = 1'b0;
                            rxb1_next[p] = 1'b0;
                            rxer_next[p] = 1'b0;
                        end
                        // Sampled at each link edge
                        if (txen_s2_reg[p]) begin
                            txv_next[p] = 1'b1;
                            txd_next[p] = {6'h00, txb1_s2_reg[p],
                                           txb0_s2_reg[p]};
                            txe_next[p] = 1'b0;
                        end
                    end
                end else if (link_edge) begin
                    for (int q = 0; q < NUM_GROUPS; q++) begin
                        if (sync_s2_reg[q]) begin
                            seg_cnt_next[q] = SEG_FIRST;
                        end else if (seg_cnt_reg[q] != SEG_IDLE) begin
                            seg_cnt_next[q] = 4'(seg_cnt_reg[q] + 1'b1);
                        end
                    end
                    for (int p = 0; p < NUM_PORTS; p++) begin
                        g = orspi_group_of(p);
                        if (sync_s2_reg[g]) begin
                            // Closed segment counts only if ten bits long
                            if (seg_cnt_reg[g] == SEG_LAST &&
                                tx_sh_reg[p][TX_EN_POS]) begin
                                txv_next[p] = 1'b1;
                                txd_next[p] = tx_sh_reg[p][9:SEG_DATA_POS];
                                txe_next[p] = tx_sh_reg[p][TX_ER_POS];
                            end
                            word = SEG_RESET;
                            word[SEG_CRS_POS] = rx_carrier[p] | buf_valid[p];
                            if (asm_cnt_reg[p] == ASM_FULL) begin
                                word[SEG_DV_POS] = 1'b1;
                                word[9:SEG_DATA_POS] = asm_reg[p];
                                asm_cnt_next[p] = ASM_RESET;
                            end
                            srx_next[p] = word[0];
                            rx_seg_next[p] = {1'b0, word[9:1]};
                        end else begin
                            srx_next[p] = rx_seg_reg[p][0];
                            rx_seg_next[p] = {1'b0, rx_seg_reg[p][9:1]};
                        end
                        tx_sh_next[p] = {stx_s2_reg[p], tx_sh_reg[p][9:1]};
                        // Gather four dibits into a byte
                        if (asm_cnt_next[p] != ASM_FULL && buf_valid[p]) begin
                            drain[p] = 1'b1;
                            asm_next[p][2*asm_cnt_next[p] +: 2] =
                                buf_data[p][1:0];
                            asm_cnt_next[p] = 3'(asm_cnt_next[p] + 1'b1);
                        end
                    end
                end
            end
            default: begin
                st_next = ORSPI_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_reg <= ORSPI_ST_RESET;
            mode_reg <= ORSPI_MODE_REDUCED;
            settle_reg <= SETTLE_RESET;
            rxb0_reg <= 8'h00;
            rxb1_reg <= 8'h00;
            csdv_reg <= 8'h00;
            rxer_reg <= 8'h00;
            srx_reg <= 8'h00;
            red_oe_n_reg <= 1'b1;
            ser_oe_n_reg <= 1'b1;
            txv_reg <= 8'h00;
            txe_reg <= 8'h00;
            txd_reg <= '0;
            seg_cnt_reg <= {SEG_IDLE, SEG_IDLE};
            rx_seg_reg <= '0;
            tx_sh_reg <= '0;
            asm_reg <= '0;
            asm_cnt_reg <= '0;
        end else begin
            st_reg <= st_next;
            mode_reg <= mode_next;
            settle_reg <= settle_next;
            rxb0_reg <= rxb0_next;
            rxb1_reg <= rxb1_next;
            csdv_reg <= csdv_next;
            rxer_reg <= rxer_next;
            srx_reg <= srx_next;
            red_oe_n_reg <= red_oe_n_next;
            ser_oe_n_reg <= ser_oe_n_next;
            txv_reg <= txv_next;
            txe_reg <= txe_next;
            txd_reg <= txd_next;
            seg_cnt_reg <= seg_cnt_next;
            rx_seg_reg <= rx_seg_next;
            tx_sh_reg <= tx_sh_next;
            asm_reg <= asm_next;
            asm_cnt_reg <= asm_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reduced_rx_bit0 = rxb0_reg;
    assign reduced_rx_bit1 = rxb1_reg;
    assign carrier_sense_data_valid = csdv_reg;
    assign reduced_rx_error = rxer_reg;
    assign reduced_out_oe_n = red_oe_n_reg;
    assign serial_rx_out = srx_reg;
    assign serial_rx_oe_n = ser_oe_n_reg;
    assign tx_valid = txv_reg;
    assign tx_data = txd_reg;
    assign tx_error = txe_reg;
    assign link_serial_mode = mode_reg;
    assign link_running = (st_reg == ORSPI_ST_RUN);
endmodule
`default_nettype wire

// ---- orspi_top_asserts.sv ----
// Concurrent checks on the port interface top
`timescale 1ns/1ps
`default_nettype none
module orspi_top_asserts
    import orspi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic link_running,
    input wire logic link_serial_mode,
    input wire logic reduced_out_oe_n,
    input wire logic serial_rx_oe_n,
    input wire logic [7:0] tx_valid,
    input wire logic [7:0] tx_error,
    input wire logic [7:0] rx_word_valid,
    input wire logic [7:0] rx_word_ready,
    input wire logic [7:0] carrier_sense_data_valid,
    input wire logic [7:0] reduced_rx_error,
    input wire logic [7:0] reduced_rx_bit0,
    input wire logic [7:0] serial_rx_out
);
    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_settle;
        !link_running ##[3:6] link_running;
    endsequence
    sequence s_hold5(x);
        $stable(x)[*5];
    endsequence
    wire logic red_run = link_running && !link_serial_mode;
    oe_reduced_a: assert property (red_run && $past(link_running)
        |-> !reduced_out_oe_n && serial_rx_oe_n) else $error("oe reduced");
    oe_serial_a: assert property (link_running && link_serial_mode
        && $past(link_running) |-> reduced_out_oe_n && !serial_rx_oe_n)
        else $error("oe serial");
    reset_oe_a: assert property (disable iff (1'b0) rst
        |=> reduced_out_oe_n && serial_rx_oe_n && !link_running)
        else $error("outputs not parked in reset");
    settle_time_a: assert property ($fell(rst) |-> s_settle)
        else $error("run state late");
    tx_gap_a: assert property (tx_valid[0] |=> !tx_valid[0] [*5])
        else $error("transmit pulses too close");
    tx_err_zero_a: assert property (red_run |-> tx_error == 8'h00)
        else $error("transmit error in reduced mode");
    csdv_follow_a: assert property (red_run && rx_word_valid[0]
        && rx_word_ready[0] |-> ##[1:12] carrier_sense_data_valid[0])
        else $error("carrier sense missing");
    rx_err_hold_a: assert property ($rose(reduced_rx_error[0])
        && red_run |=> reduced_rx_error[0] [*6])
        else $error("receive error too short");
    rx_bit_sync_a: assert property ($changed(reduced_rx_bit0)
        |=> s_hold5(reduced_rx_bit0)) else $error("receive bits off clock");
    srx_sync_a: assert property ($changed(serial_rx_out)
        |=> s_hold5(serial_rx_out)) else $error("serial bits off clock");
endmodule
bind orspi_top orspi_top_asserts u_chk (.ref_clk(ref_clk), .rst(rst),
    .link_running(link_running), .link_serial_mode(link_serial_mode),
    .reduced_out_oe_n(reduced_out_oe_n), .serial_rx_oe_n(serial_rx_oe_n),
    .tx_valid(tx_valid), .tx_error(tx_error), .rx_word_valid(rx_word_valid),
    .rx_word_ready(rx_word_ready), .reduced_rx_bit0(reduced_rx_bit0),
    .carrier_sense_data_valid(carrier_sense_data_valid),
    .reduced_rx_error(reduced_rx_error), .serial_rx_out(serial_rx_out));
`default_nettype wire

// ---- orspi_mac_model.sv ----
// Behavioural switch-side MAC facing the port interface
`timescale 1ns/1ps
`default_nettype none
module orspi_mac_model
    import orspi_pkg::*;
(
    input wire logic serial_on,
    output logic link_clk,
    output logic [7:0] tx_b0,
    output logic [7:0] tx_b1,
    output logic [7:0] tx_en,
    output logic [7:0] stx,
    output logic [1:0] sync,
    output logic [7:0] cap_b0,
    output logic [7:0] cap_b1,
    output logic [7:0] cap_en,
    output logic [7:0][7:0] done_byte,
    output logic [7:0] done_er
);
    logic [7:0][9:0] seg;
    int idx;
    // ----------------
    // Link clock and pins
    // ----------------
    initial begin
        {tx_b0, tx_b1, tx_en, stx, sync} = '0;
        {cap_b0, cap_b1, cap_en, done_byte, done_er, seg} = '0;
        idx = 0;
        link_clk = 1'b0;
        #3;
        forever #40 link_clk = ~link_clk;
    end
    always @(posedge link_clk) begin
        cap_b0 <= tx_b0;
        cap_b1 <= tx_b1;
        cap_en <= tx_en;
    end
    always @(negedge link_clk) begin
        tx_b0 <= 8'($urandom);
        tx_b1 <= 8'($urandom);
        tx_en <= 8'($urandom);
        idx = (idx + 1) % 10;
        for (int p = 0; p < 8; p++) begin
            if (idx == 0) begin
                done_byte[p] <= seg[p][9:2];
                done_er[p] <= seg[p][0];
                seg[p] = {8'($urandom), 1'b1, 1'($urandom)};
            end
            stx[p] <= serial_on ? seg[p][idx] : 1'($urandom);
        end
        sync <= serial_on ? {2{idx == 0}} : 2'($urandom);
    end
endmodule
`default_nettype wire

// ---- orspi_top_tb.sv ----
// Self-checking bench of the port interface top
`timescale 1ns/1ps
`default_nettype none
module orspi_top_tb;
    import orspi_pkg::*;
    logic ref_clk, rst, strap, link_clk, roe, soe, lsm, lrun;
    logic [7:0] tb0, tb1, ten, stx, rxv, rxr, rxe, rxc, rb0, rb1, csdv;
    logic [7:0] rer, srx, txv, txe, cb0, cb1, cen, der;
    logic [1:0] sync;
    logic [7:0][1:0] rxd;
    logic [7:0][7:0] txd, dby, rx_exp;
    logic [7:0][9:0] win;
    logic [8:0] exp_seg;
    logic [3:0][7:0][1:0] w4;
    logic srx_on;
    int bpos[8] = '{default: 10};
    int error_cnt, checked, pulses, cyc, rx_seen;
    orspi_top u_dut (.ref_clk(ref_clk), .rst(rst),
        .shared_reference_clock(link_clk), .serial_mode_strap(strap),
        .reduced_tx_bit0(tb0), .reduced_tx_bit1(tb1), .reduced_tx_enable(ten),
        .reduced_rx_bit0(rb0), .reduced_rx_bit1(rb1),
        .carrier_sense_data_valid(csdv), .reduced_rx_error(rer),
        .reduced_out_oe_n(roe), .serial_tx_in(stx), .serial_rx_out(srx),
        .serial_rx_oe_n(soe), .serial_segment_sync(sync), .rx_word_valid(rxv),
        .rx_word_ready(rxr), .rx_dibit(rxd), .rx_word_error(rxe),
        .rx_carrier(rxc), .tx_valid(txv), .tx_data(txd), .tx_error(txe),
        .link_serial_mode(lsm), .link_running(lrun));
    orspi_mac_model u_mac (.serial_on(strap), .link_clk(link_clk),
        .tx_b0(tb0), .tx_b1(tb1), .tx_en(ten), .stx(stx), .sync(sync),
        .cap_b0(cb0), .cap_b1(cb1), .cap_en(cen), .done_byte(dby),
        .done_er(der));
    // ----------------
    // Helpers
    // ----------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] bit_of(input logic [7:0][1:0] w, int b);
        for (int p = 0; p < 8; p++) begin
            bit_of[p] = w[p][b];
        end
    endfunction
    function automatic logic [7:0][7:0] bytes_of(
        input logic [3:0][7:0][1:0] w);
        for (int p = 0; p < 8; p++) begin
            for (int k = 0; k < 4; k++) begin
                bytes_of[p][2*k +: 2] = w[k][p];
            end
        end
    endfunction
    task automatic push_word(input logic [7:0][1:0] w, input logic [7:0] er);
        rxd = w;
        rxe = er;
        rxv = 8'hff;
        while (rxr != 8'hff) begin
            @(negedge ref_clk);
        end
        @(negedge ref_clk);
    endtask
    task automatic do_reset(input logic mode);
        rst = 1'b1;
        strap = mode;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk({lrun, roe, soe, lsm}, {1'b1, mode, ~mode, mode});
    endtask
    task automatic rx_round();
        logic [1:0][7:0][1:0] d;
        logic [1:0][7:0] e;
        d = 32'($urandom);
        e = 16'($urandom);
        @(negedge link_clk);
        @(negedge ref_clk);
        for (int i = 0; i < 2; i++) begin
            push_word(d[i], e[i]);
        end
        rxv = 8'h00;
        chk(rxr, 8'h00);
        for (int i = 0; i < 3; i++) begin
            @(posedge link_clk);
            @(negedge link_clk);
            repeat (3) @(negedge ref_clk);
            if (i < 2) begin
                chk({rb1, rb0}, {bit_of(d[i], 1), bit_of(d[i], 0)});
                chk(rer, e[i]);
            end
            chk({csdv, rxr}, {(i < 2) ? 8'hff : 8'h00, 8'hff});
        end
    endtask
    // ----------------
    // Clock, monitor and sequence
    // ----------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run();
        end else begin
            for (int p = 0; p < 8; p++) begin
                if (!rst && txv[p] && lsm) begin
                    pulses++;
                    chk({txe[p], txd[p]}, {der[p], dby[p]});
                end else if (!rst && txv[p]) begin
                    pulses++;
                    chk(cen[p], 1'b1);
                    chk(txd[p], {6'h0, cb1[p], cb0[p]});
                end
            end
        end
    end
    // Serial receive segments, one bit per link period
    always @(negedge link_clk) begin
        for (int p = 0; p < 8; p++) begin
            if (srx_on) begin
                bpos[p] = sync[p / 4] ? 0 : bpos[p] + 1;
                win[p][bpos[p] % 10] = srx[p];
                if (bpos[p] == 9) begin
                    exp_seg = win[p][1] ? {rx_exp[p], 1'b1} : 9'h000;
                    chk(win[p][0], 1'b1);
                    chk(win[p][9:1], exp_seg);
                    rx_seen += int'(win[p][1]);
                end
            end
        end
    end
    initial begin
        void'($urandom(32'h4a59));
        {error_cnt, checked, pulses, cyc, rx_seen} = '0;
        {rst, strap, rxv, rxe, rxc, rxd, srx_on} = '0;
        do_reset(1'b0);
        repeat (6) rx_round();
        chk(64'(pulses > 0), 64'h1);
        do_reset(1'b1);
        pulses = 0;
        rxc = 8'hff;
        @(posedge link_clk);
        srx_on = 1'b1;
        @(negedge ref_clk);
        for (int b = 0; b < 3; b++) begin
            w4 = {$urandom, $urandom};
            rx_exp = bytes_of(w4);
            for (int k = 0; k < 4; k++) begin
                push_word(w4[k], 8'($urandom));
            end
            rxv = 8'h00;
            wait (rx_seen == 8 * (b + 1));
            @(negedge ref_clk);
        end
        chk(64'(pulses > 0), 64'h1);
        chk(64'(rx_seen), 64'h18);
        complete_run();
    end
endmodule
`default_nettype wire
